// ===== include/uoe_pkg.sv
// shared constants and types for the usb out/setup endpoint engine
package uoe_pkg;
   // ********************************************
   // register map (byte addresses)
   // ********************************************
   localparam logic [7:0] A_NEGO = 8'h00;
   localparam logic [7:0] A_SETUP_CTL = 8'h04;
   localparam logic [7:0] A_EP0_IN = 8'h08;
   localparam logic [2:0] A_SETUP_HI = 3'h1; // 0x20..0x3C: setup bytes
   localparam logic [1:0] A_EP_HI = 2'h1; // 0x40 + 8*ep ctrl, +4 status
   // endpoint slots: 0 = ep0 out, 1..5 = general, 6 = ep0 in
   localparam int EP_SLOTS = 7;
   localparam logic [2:0] EP_LAST_OUT = 3'h5;
   localparam logic [2:0] EP0_IN_SLOT = 3'h6;
   // ********************************************
   // control word fields
   // ********************************************
   localparam int B_NAK = 0;
   localparam int B_STALL = 1;
   localparam int B_AUTO = 2;
   localparam int B_PERMIT = 3;
   localparam int B_INHIBIT = 4;
   localparam int B_TOGGLE = 5;
   localparam int B_T1 = 6;
   localparam int B_T0 = 7;
   localparam int B_ISO = 8;
   localparam int B_MPS = 16;
   localparam int MPS_W = 11;
   localparam logic [10:0] MPS_RST = 11'h040;
   // status word fields
   localparam int F_ACK = 0;
   localparam int F_SHORT = 1;
   localparam int F_NAK = 2;
   localparam int F_ERR = 3;
   // setup control fields (B_ACTIVE is the nego register field)
   localparam int B_LOCK = 0;
   localparam int B_SETUP_FLAG = 1;
   localparam int B_ACTIVE = 0;
   // ********************************************
   // setup packet
   // ********************************************
   localparam logic [11:0] SETUP_LEN = 12'h008;
   localparam logic [7:0] REQ_TYPE_STD_DEV = 8'h00;
   localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
   typedef enum logic [1:0] {
      UOE_HS_ACK = 2'b00, UOE_HS_NAK = 2'b01, UOE_HS_STALL = 2'b10, UOE_HS_NYET = 2'b11
   } uoe_hs_t;
   typedef enum logic [0:0] {UOE_ST_IDLE = 1'b0, UOE_ST_RX = 1'b1} uoe_st_t;
   typedef enum logic [2:0] {
      UOE_M_SETUP = 3'b000, UOE_M_STALL = 3'b001, UOE_M_NAK = 3'b010,
      UOE_M_FULL = 3'b011, UOE_M_ACCEPT = 3'b100
   } uoe_mode_t;
endpackage

// ===== hdl/uoe_ep_reg.sv
// control and status bits of one endpoint slot
module uoe_ep_reg (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic ctl_wr,
   input wire logic stat_wr,
   input wire logic [31:0] wdata,
   input wire logic lock,
   input wire logic ev_done,
   input wire logic ev_short,
   input wire logic ev_nak,
   input wire logic ev_err,
   input wire logic ev_setup,
   input wire logic ev_short_sent,
   output logic forced_nak,
   output logic forced_stall,
   output logic toggle_state,
   output logic iso,
   output logic [10:0] mps,
   output logic [31:0] ctl_rd,
   output logic [3:0] stat_rd
);
   typedef struct packed {
      logic nak; logic stall; logic auto_nak_arm; logic short_packet_permit;
      logic short_rx_nak_inhibit; logic toggle; logic iso; logic [10:0] mps;
      logic [3:0] flags;
   } uoe_ep_s_t;
   uoe_ep_s_t r, next_r;

   // ********************************************
   // next state: firmware first, hardware events win
   // ********************************************
   always_comb begin
      next_r = r;
      if (ctl_wr) begin
         if (!lock) begin // lock refuses nak/stall writes
            next_r.nak = wdata[uoe_pkg::B_NAK];
            next_r.stall = wdata[uoe_pkg::B_STALL];
         end
         next_r.auto_nak_arm = wdata[uoe_pkg::B_AUTO];
         next_r.short_packet_permit = wdata[uoe_pkg::B_PERMIT];
         next_r.short_rx_nak_inhibit = wdata[uoe_pkg::B_INHIBIT];
         next_r.iso = wdata[uoe_pkg::B_ISO];
         next_r.mps = wdata[uoe_pkg::B_MPS +: uoe_pkg::MPS_W];
         if (wdata[uoe_pkg::B_T1]) begin
            next_r.toggle = 1'b1;
         end else if (wdata[uoe_pkg::B_T0]) begin
            next_r.toggle = 1'b0;
         end
      end
      if (stat_wr) begin
         next_r.flags = r.flags & ~wdata[3:0]; // write one to clear
      end
      if (ev_done) begin
         next_r.flags[uoe_pkg::F_ACK] = 1'b1;
         if (!r.iso) begin
            next_r.toggle = ~r.toggle;
         end
         if (r.auto_nak_arm) begin
            next_r.nak = 1'b1;
         end
         if (ev_short) begin
            next_r.flags[uoe_pkg::F_SHORT] = 1'b1;
            if (!r.short_rx_nak_inhibit) begin
               next_r.nak = 1'b1;
            end
         end
      end
      if (ev_nak) begin
         next_r.flags[uoe_pkg::F_NAK] = 1'b1;
      end
      if (ev_err) begin
         next_r.flags[uoe_pkg::F_ERR] = 1'b1;
      end
      if (ev_setup) begin
         next_r.nak = 1'b1;
         next_r.stall = 1'b0;
         next_r.toggle = 1'b1;
      end
      if (ev_short_sent) begin
         next_r.short_packet_permit = 1'b0;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{mps: uoe_pkg::MPS_RST, default: '0};
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign forced_nak = r.nak;
   assign forced_stall = r.stall;
   assign toggle_state = r.toggle;
   assign iso = r.iso;
   assign mps = r.mps;
   assign stat_rd = r.flags;
   // force bits read as zero
   assign ctl_rd = {5'h00, r.mps, 7'h00, r.iso, 2'b00, r.toggle, r.short_rx_nak_inhibit,
                    r.short_packet_permit, r.auto_nak_arm, r.stall, r.nak};
endmodule // uoe_ep_reg

// ===== hdl/uoe_setup_store.sv
// eight-byte store for the last setup packet
module uoe_setup_store (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic wr,
   input wire logic [2:0] widx,
   input wire logic [7:0] wdata,
   input wire logic [2:0] ridx,
   output logic [7:0] rdata
);
   typedef struct packed {
      logic [7:0][7:0] bytes;
   } uoe_ss_t;
   uoe_ss_t r, next_r;

   // byte write
   always_comb begin
      next_r = r;
      if (wr) begin
         next_r.bytes[widx] = wdata;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign rdata = r.bytes[ridx];
endmodule // uoe_setup_store

// ===== hdl/uoe_engine.sv
// usb device setup and out-transaction engine with apb registers
//
// Our own choices: the register offsets and register access over APB.
module uoe_engine (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tok_valid,
   input wire logic tok_setup,
   input wire logic [2:0] tok_ep,
   input wire logic [15:0] fifo_free,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_end,
   input wire logic rx_err,
   input wire logic rx_data1,
   input wire logic in_done,
   input wire logic [2:0] in_done_ep,
   input wire logic in_done_short,
   output logic hs_valid,
   output logic [1:0] hs_pid,
   output logic fifo_wr_valid,
   output logic [7:0] fifo_wr_data,
   output logic [2:0] fifo_ep,
   output logic fifo_commit,
   output logic fifo_discard,
   output logic usb_function_active
);
   typedef struct packed {
      uoe_pkg::uoe_st_t st;
      uoe_pkg::uoe_mode_t mode;
      logic [2:0] ep;
      logic iso;
      logic toggle;
      logic [10:0] mps;
      logic [15:0] free;
      logic [11:0] count;
      logic [7:0] req0;
      logic [7:0] req1;
      logic active;
      logic lock;
      logic setup_flag;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic hs_valid;
      logic [1:0] hs_pid;
      logic wr_valid;
      logic [7:0] wr_data;
      logic commit;
      logic discard;
   } uoe_eng_t;
   uoe_eng_t r, next_r;

   localparam int N = uoe_pkg::EP_SLOTS;
   logic [N-1:0] ev_done, ev_short, ev_nak, ev_err, ev_setup, ev_sent, ctl_wr, stat_wr;
   logic [N-1:0] ep_nak, ep_stall, ep_tog, ep_iso;
   logic [10:0] ep_mps [N];
   logic [31:0] ep_ctl [N];
   logic [3:0] ep_stat [N];
   logic ss_wr;
   logic [7:0] ss_rdata;
   logic acc;
   logic [2:0] slot;
   logic slot_ok;
   logic [15:0] rem;
   logic [2:0] in_slot;

   // ********************************************
   // endpoint slots and setup byte store
   // ********************************************
   for (genvar i = 0; i < N; i++) begin : g_ep
      localparam bit EP0 = (i == 0) || (i == N - 1);
      uoe_ep_reg u_ep (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .ctl_wr(ctl_wr[i]),
         .stat_wr(stat_wr[i]),
         .wdata(pwdata),
         .lock(r.lock & EP0),
         .ev_done(ev_done[i]),
         .ev_short(ev_short[i]),
         .ev_nak(ev_nak[i]),
         .ev_err(ev_err[i]),
         .ev_setup(ev_setup[i]),
         .ev_short_sent(ev_sent[i]),
         .forced_nak(ep_nak[i]),
         .forced_stall(ep_stall[i]),
         .toggle_state(ep_tog[i]),
         .iso(ep_iso[i]),
         .mps(ep_mps[i]),
         .ctl_rd(ep_ctl[i]),
         .stat_rd(ep_stat[i])
      );
   end

   uoe_setup_store u_setup (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .wr(ss_wr),
      .widx(r.count[2:0]),
      .wdata(rx_data),
      .ridx(paddr[4:2]),
      .rdata(ss_rdata)
   );

   // ********************************************
   // next state: apb slave and transaction engine
   // ********************************************
   always_comb begin
      next_r = r;
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      next_r.hs_valid = 1'b0;
      next_r.wr_valid = 1'b0;
      next_r.commit = 1'b0;
      next_r.discard = 1'b0;
      {ev_done, ev_short, ev_nak, ev_err, ev_setup, ev_sent, ctl_wr, stat_wr} = '0;
      ss_wr = 1'b0;
      rem = r.free - {4'h0, r.count};
      // endpoint slot decode: 0x40 + 8 * slot
      slot = paddr[5:3];
      slot_ok = (paddr[7:6] == uoe_pkg::A_EP_HI) && (slot <= uoe_pkg::EP_LAST_OUT);
      acc = psel & penable & r.pready & ~r.pslverr;
      // setup phase: answer on the first access cycle, unmapped gets pslverr
      if (psel && !penable) begin
         next_r.pready = 1'b1;
         next_r.prdata = 32'h0000_0000;
         if (paddr[1:0] != 2'b00) begin
            next_r.pslverr = 1'b1;
         end else if (paddr == uoe_pkg::A_NEGO) begin
            next_r.prdata[uoe_pkg::B_ACTIVE] = r.active;
         end else if (paddr == uoe_pkg::A_SETUP_CTL) begin
            next_r.prdata[uoe_pkg::B_LOCK] = r.lock;
            next_r.prdata[uoe_pkg::B_SETUP_FLAG] = r.setup_flag;
         end else if (paddr == uoe_pkg::A_EP0_IN) begin
            next_r.prdata = ep_ctl[uoe_pkg::EP0_IN_SLOT];
         end else if (paddr[7:5] == uoe_pkg::A_SETUP_HI) begin
            next_r.prdata = {24'h000000, ss_rdata};
         end else if (slot_ok) begin
            next_r.prdata = paddr[2] ? {28'h0000000, ep_stat[slot]} : ep_ctl[slot];
         end else begin
            next_r.pslverr = 1'b1;
         end
      end
      // access phase: writes land on the edge that samples pready
      if (acc && pwrite) begin
         if (paddr == uoe_pkg::A_NEGO) begin
            next_r.active = pwdata[uoe_pkg::B_ACTIVE];
         end else if (paddr == uoe_pkg::A_SETUP_CTL) begin
            if (!pwdata[uoe_pkg::B_LOCK]) begin
               next_r.lock = 1'b0; // firmware may release the lock
            end
            if (pwdata[uoe_pkg::B_SETUP_FLAG]) begin
               next_r.setup_flag = 1'b0;
            end
         end else if (paddr == uoe_pkg::A_EP0_IN) begin
            ctl_wr[uoe_pkg::EP0_IN_SLOT] = 1'b1;
         end else if (slot_ok) begin
            ctl_wr[slot] = ~paddr[2];
            stat_wr[slot] = paddr[2];
         end
      end
      // short packet sent on an in endpoint; ep0 in lives in the last slot
      in_slot = (in_done_ep == 3'h0) ? uoe_pkg::EP0_IN_SLOT : in_done_ep;
      ev_sent[in_slot] = in_done & in_done_short;
      // transaction engine
      case (r.st)
         uoe_pkg::UOE_ST_IDLE: begin
            if (tok_valid) begin
               next_r.ep = tok_ep;
               next_r.count = 12'h000;
               next_r.free = fifo_free;
               if (tok_setup) begin
                  // ep0 setup bypasses nak and stall
                  if (r.active && tok_ep == 3'h0) begin
                     next_r.st = uoe_pkg::UOE_ST_RX;
                     next_r.mode = uoe_pkg::UOE_M_SETUP;
                     next_r.iso = 1'b0;
                  end
               end else if (tok_ep <= uoe_pkg::EP_LAST_OUT) begin
                  next_r.st = uoe_pkg::UOE_ST_RX;
                  next_r.iso = ep_iso[tok_ep];
                  next_r.mps = ep_mps[tok_ep];
                  next_r.toggle = ep_tog[tok_ep];
                  if (ep_stall[tok_ep]) begin
                     next_r.mode = uoe_pkg::UOE_M_STALL;
                  end else if (ep_nak[tok_ep]) begin
                     next_r.mode = uoe_pkg::UOE_M_NAK;
                  end else if (fifo_free > {5'h00, ep_mps[tok_ep]}) begin
                     next_r.mode = uoe_pkg::UOE_M_ACCEPT;
                  end else begin
                     next_r.mode = uoe_pkg::UOE_M_FULL;
                  end
               end
            end
         end
         uoe_pkg::UOE_ST_RX: begin
            if (rx_valid) begin
               if (r.count != 12'hFFF) begin
                  next_r.count = r.count + 12'h001;
               end
               if (r.mode == uoe_pkg::UOE_M_SETUP && r.count < uoe_pkg::SETUP_LEN) begin
                  ss_wr = 1'b1;
                  if (r.count == 12'h000) begin
                     next_r.req0 = rx_data;
                  end
                  if (r.count == 12'h001) begin
                     next_r.req1 = rx_data;
                  end
               end
               if (r.mode == uoe_pkg::UOE_M_ACCEPT) begin
                  next_r.wr_valid = 1'b1;
                  next_r.wr_data = rx_data;
               end
            end
            if (rx_end) begin
               next_r.st = uoe_pkg::UOE_ST_IDLE;
               next_r.hs_valid = ~r.iso; // iso never handshakes
               next_r.hs_pid = uoe_pkg::UOE_HS_ACK;
               case (r.mode)
                  uoe_pkg::UOE_M_SETUP: begin
                     if (rx_err || r.count != uoe_pkg::SETUP_LEN) begin
                        next_r.hs_valid = 1'b0;
                     end else begin
                        ev_setup[0] = 1'b1;
                        ev_setup[uoe_pkg::EP0_IN_SLOT] = 1'b1;
                        next_r.lock = 1'b1;
                        // set-address is handled without waking firmware
                        if (!(r.req0 == uoe_pkg::REQ_TYPE_STD_DEV
                              && r.req1 == uoe_pkg::REQ_SET_ADDRESS)) begin
                           next_r.setup_flag = 1'b1;
                        end
                     end
                  end
                  uoe_pkg::UOE_M_STALL: begin
                     next_r.hs_pid = uoe_pkg::UOE_HS_STALL;
                  end
                  uoe_pkg::UOE_M_NAK, uoe_pkg::UOE_M_FULL: begin
                     next_r.hs_pid = uoe_pkg::UOE_HS_NAK;
                     ev_nak[r.ep] = 1'b1;
                  end
                  uoe_pkg::UOE_M_ACCEPT: begin
                     if (rx_err) begin
                        next_r.hs_valid = 1'b0;
                        next_r.discard = 1'b1;
                        ev_err[r.ep] = 1'b1;
                     end else if (!r.iso && rx_data1 != r.toggle) begin
                        next_r.discard = 1'b1; // ack, silently dropped
                     end else if (r.count > {1'b0, r.mps}) begin
                        next_r.hs_pid = uoe_pkg::UOE_HS_NAK;
                        next_r.discard = 1'b1;
                        ev_nak[r.ep] = 1'b1;
                     end else begin
                        next_r.commit = 1'b1;
                        ev_done[r.ep] = 1'b1;
                        ev_short[r.ep] = r.count < {1'b0, r.mps};
                        // nyet when the next packet would not fit
                        if (rem <= {5'h00, r.mps}) begin
                           next_r.hs_pid = uoe_pkg::UOE_HS_NYET;
                        end
                     end
                  end
                  default: begin
                     next_r.hs_valid = 1'b0;
                  end
               endcase
            end
         end
         default: begin
            next_r.st = uoe_pkg::UOE_ST_IDLE;
         end
      endcase
   end

   // state register; hardware set of flags wins over firmware clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{st: uoe_pkg::UOE_ST_IDLE, mode: uoe_pkg::UOE_M_SETUP, default: '0};
      end else if (ce) begin
         r <= next_r;
      end
   end

   // outputs straight from the state register
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign hs_valid = r.hs_valid;
   assign hs_pid = r.hs_pid;
   assign fifo_wr_valid = r.wr_valid;
   assign fifo_wr_data = r.wr_data;
   assign fifo_ep = r.ep;
   assign fifo_commit = r.commit;
   assign fifo_discard = r.discard;
   assign usb_function_active = r.active;
endmodule // uoe_engine

// ===== verification/uoe_host_model.sv
// usb host model: drives tokens and data packets into the engine
module uoe_host_model (
   input wire logic pclk,
   output logic tok_valid,
   output logic tok_setup,
   output logic [2:0] tok_ep,
   output logic [15:0] fifo_free,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_end,
   output logic rx_err,
   output logic rx_data1
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] pkt [0:31];
   // quiet bus until the first token
   initial begin
      {tok_valid, tok_setup, tok_ep, fifo_free, rx_valid} = '0;
      {rx_data, rx_end, rx_err, rx_data1} = '0;
   end
   // ****
   // one transaction: token, n bytes with gap idle cycles each, end marker
   // ****
   task automatic xfer(input logic s, input logic [2:0] ep, input logic [15:0] fr,
      input int n, input logic er, input logic d1, input int gap);
      @(posedge pclk);
      {tok_valid, tok_setup, tok_ep, fifo_free} <= {1'b1, s, ep, fr};
      @(posedge pclk);
      tok_valid <= 1'b0;
      fifo_free <= ~fr; // count is only valid with the token
      for (int i = 0; i < n; i++) begin
         {rx_valid, rx_data} <= {1'b1, pkt[i]};
         @(posedge pclk);
         if (gap > 0) begin
            {rx_valid, rx_data} <= {1'b0, ~pkt[i]}; // released lines never repeat the byte
            repeat (gap) @(posedge pclk);
         end
      end
      {rx_valid, rx_data, rx_end, rx_err, rx_data1} <= {1'b0, rx_data + 8'h3B, 1'b1, er, d1};
      @(posedge pclk);
      {rx_end, rx_err, rx_data1} <= {1'b0, ~er, ~d1};
   endtask
endmodule // uoe_host_model

// ===== verification/uoe_engine_sva.sv
// assertions on the engine's usb answers and apb answer timing
module uoe_engine_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_end,
   input wire logic rx_err,
   input wire logic hs_valid,
   input wire logic fifo_wr_valid,
   input wire logic [7:0] fifo_wr_data,
   input wire logic fifo_commit,
   input wire logic fifo_discard,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ****
   // answers follow their causes by exactly one cycle
   // ****
   property p_hs_cause; hs_valid |-> $past(rx_end); endproperty
   a_hs_cause: assert property (p_hs_cause) else $error("handshake without end");
   property p_err_quiet; rx_end && rx_err |=> !hs_valid && !fifo_commit; endproperty
   a_err_quiet: assert property (p_err_quiet) else $error("answered");
   property p_commit_cause; fifo_commit |-> $past(rx_end) && !$past(rx_err); endproperty
   a_commit_cause: assert property (p_commit_cause) else $error("bad commit");
   property p_discard_cause; fifo_discard |-> $past(rx_end); endproperty
   a_discard_cause: assert property (p_discard_cause) else $error("bad discard");
   property p_excl; fifo_commit |-> !fifo_discard; endproperty
   a_excl: assert property (p_excl) else $error("commit with discard");
   property p_wr_cause; fifo_wr_valid |-> $past(rx_valid); endproperty
   a_wr_cause: assert property (p_wr_cause) else $error("fifo write without byte");
   property p_wr_data; fifo_wr_valid |-> fifo_wr_data == $past(rx_data); endproperty
   a_wr_data: assert property (p_wr_data) else $error("fifo byte differs");
   property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
   a_apb: assert property (p_apb) else $error("apb answer timing");
endmodule // uoe_engine_sva
bind uoe_engine uoe_engine_sva chk_u (.pclk, .presetn, .rx_valid, .rx_data, .rx_end, .rx_err,
   .hs_valid, .fifo_wr_valid, .fifo_wr_data, .fifo_commit, .fifo_discard, .psel, .penable,
   .pready);

// ===== verification/uoe_engine_tb.sv
// self-checking bench for the usb out/setup endpoint engine
module uoe_engine_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] M16 = 32'h00100000, M8 = 32'h00080100, T1 = 32'h40, T0 = 32'h80;
   logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic in_done = 1'b0, in_done_short = 1'b0, perr;
   logic [2:0] in_done_ep = 3'h0, tok_ep, fifo_ep, hs_got;
   logic [7:0] paddr = 8'h00, rx_data, fifo_wr_data;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] fifo_free;
   logic [1:0] hs_pid;
   logic pready, pslverr, tok_valid, tok_setup, rx_valid, rx_end, rx_err, rx_data1;
   logic hs_valid, fifo_wr_valid, fifo_commit, fifo_discard, usb_function_active;
   int fail_count = 0, num_checks = 0, commits = 0, seed = 32'h4267;
   uoe_engine dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .tok_valid, .tok_setup, .tok_ep, .fifo_free, .rx_valid, .rx_data,
      .rx_end, .rx_err, .rx_data1, .in_done, .in_done_ep, .in_done_short, .hs_valid, .hs_pid,
      .fifo_wr_valid, .fifo_wr_data, .fifo_ep, .fifo_commit, .fifo_discard, .usb_function_active);
   uoe_host_model host_u (.pclk, .tok_valid, .tok_setup, .tok_ep, .fifo_free, .rx_valid,
      .rx_data, .rx_end, .rx_err, .rx_data1);
   always #25 pclk = ~pclk;
   // what the host sees; 4 in hs_got means silence
   always @(posedge pclk) begin
      if (hs_valid) hs_got <= {1'b0, hs_pid};
      if (fifo_commit) commits <= commits + 1;
   end
   // ****
   // apb master, compare and expectation helpers
   // ****
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1); // watchdog bounds this wait
      {rd, perr} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask
   // control read-back: toggle controls read 0, toggle state in bit 5
   function automatic logic [31:0] ectl(input logic [31:0] c, input logic nk, input logic tg);
      return (c & 32'h07FF011E) | {26'h0, tg, 4'h0, nk};
   endfunction
   task automatic su(input logic er, input logic [7:0] b1, input logic [2:0] eh,
      input logic [31:0] esc);
      for (int i = 0; i < 8; i++) host_u.pkt[i] = 8'($random(seed));
      {host_u.pkt[0], host_u.pkt[1], hs_got} = {8'h00, b1, 3'h4};
      host_u.xfer(1'b1, 3'h0, 16'h0, 8 - er, er, 1'b0, 0); // short erroneous packet on error
      apb(1'b0, 8'h04, 32'h0);
      cmp(32'(hs_got), 32'(eh));
      cmp(rd, esc);
      if (eh == 3'h0) begin
         for (int i = 0; i < 8; i++) rdc(8'h20 + 8'(4 * i), 32'(host_u.pkt[i]));
         rdc(8'h40, 32'h00400021);
         rdc(8'h08, 32'h00400021);
      end
   endtask
   // one out transaction; outcome follows the documented decision order
   task automatic run(input logic [2:0] ep, input logic [31:0] c, input logic [15:0] fr,
      input int n, input logic er, input logic d1);
      logic [7:0] a = 8'h40 + {2'b00, ep, 3'h0};
      logic [2:0] eh = 3'h4;
      logic [3:0] es = 4'h0;
      logic nk = c[0];
      logic tg = c[6];
      int good = 0;
      apb(1'b1, a, c);
      apb(1'b1, a + 8'h04, 32'h0000000F);
      rdc(a, ectl(c, nk, tg));
      for (int i = 0; i < 32; i++) host_u.pkt[i] = 8'($random(seed));
      {hs_got, commits} = {3'h4, 32'h0};
      host_u.xfer(1'b0, ep, fr, n, er, d1, n % 3);
      if (c[1]) eh = 3'h2;
      else if (c[0] || fr <= c[26:16]) {eh, es} = {c[8] ? 3'h4 : 3'h1, 4'h4};
      else if (er) es = 4'h8;
      else if (!c[8] && d1 != c[6]) eh = 3'h0;
      else if (n > c[26:16]) {eh, es} = {c[8] ? 3'h4 : 3'h1, 4'h4};
      else begin
         eh = c[8] ? 3'h4 : ((fr - n <= c[26:16]) ? 3'h3 : 3'h0);
         es = {2'b00, n < c[26:16], 1'b1};
         nk = c[2] | (n < c[26:16] && !c[4]);
         tg = c[6] ^ !c[8];
         good = 1;
      end
      apb(1'b0, a + 8'h04, 32'h0);
      cmp(32'(fifo_ep), 32'(ep));
      cmp(32'(hs_got), 32'(eh));
      cmp(32'(commits), 32'(good));
      cmp(rd, 32'(es));
      rdc(a, ectl(c, nk, tg));
   endtask
   task automatic complete_run();
      if (fail_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // hang guard, far beyond the thousand or so cycles the sequence needs
   initial begin
      repeat (30000) @(posedge pclk);
      fail_count++;
      complete_run();
   end
   // ****
   // main sequence
   // ****
   initial begin
      int n;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdc(8'h48, 32'h00400000);
      apb(1'b0, 8'h3E, 32'h0);
      cmp(32'(perr), 32'h1);
      cmp(32'(usb_function_active), 32'h0);
      su(1'b0, 8'h06, 3'h4, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      rdc(8'h00, 32'h1);
      cmp(32'(usb_function_active), 32'h1);
      apb(1'b1, 8'h40, 32'h00400002);
      apb(1'b1, 8'h08, 32'h00400002);
      su(1'b0, 8'h06, 3'h0, 32'h3);
      apb(1'b1, 8'h40, 32'h00400000);
      rdc(8'h40, 32'h00400021);
      apb(1'b1, 8'h04, 32'h2);
      apb(1'b1, 8'h40, 32'h00400000);
      rdc(8'h40, 32'h00400020);
      su(1'b1, 8'h06, 3'h4, 32'h0);
      su(1'b0, 8'h05, 3'h0, 32'h1);
      apb(1'b1, 8'h04, 32'h0);
      run(3'h1, M16 | 32'h82, 16'h40, 4, 1'b0, 1'b0);
      run(3'h1, M16 | 32'h81, 16'h40, 4, 1'b0, 1'b0);
      run(3'h1, M16 | T0, 16'h10, 4, 1'b0, 1'b0);
      run(3'h1, M16 | T0, 16'h40, 4, 1'b1, 1'b0);
      run(3'h1, M16 | T0, 16'h40, 4, 1'b0, 1'b1);
      run(3'h1, M16 | T0, 16'h40, 17, 1'b0, 1'b0);
      run(3'h2, M16 | T1 | 32'h4, 16'h40, 16, 1'b0, 1'b1);
      run(3'h2, M16 | T0, 16'h14, 16, 1'b0, 1'b0);
      run(3'h3, M8 | T0, 16'h10, 8, 1'b0, 1'b0);
      run(3'h3, M8 | T0, 16'h08, 4, 1'b0, 1'b0);
      run(3'h3, M8 | T0, 16'h10, 3, 1'b0, 1'b1);
      run(3'h3, M8 | T0 | 32'h10, 16'h10, 3, 1'b0, 1'b0);
      run(3'h3, M8 | T0, 16'h10, 8, 1'b1, 1'b0);
      run(3'h3, M8 | T0, 16'h10, 9, 1'b0, 1'b0);
      for (int k = 0; k < 8; k++) begin
         n = 1 + ($random(seed) & 15);
         run(3'(1 + k % 5), M16 | (k[0] ? T1 : T0) | 32'($random(seed) & 16),
            16'(17 + ($random(seed) & 63)), n, 1'b0, k[0]);
      end
      apb(1'b1, 8'h48, 32'h00100088);
      // first pulse with the clock enable low must leave the permit bit alone
      for (int j = 0; j < 2; j++) begin
         @(posedge pclk);
         {ce, in_done, in_done_ep, in_done_short} <= {j[0], 1'b1, 3'h1, 1'b1};
         @(posedge pclk);
         {ce, in_done} <= 2'b10;
         rdc(8'h48, j ? 32'h00100000 : 32'h00100008);
      end
      complete_run();
   end
endmodule // uoe_engine_tb
